// File: design/nand_cfg_pkg.sv
/*
 Constants for the NAND controller configuration, control and status block:
 register byte addresses, field positions, reset values and the timeout FSM.
 Assumes a 32-bit register port decoded on full byte addresses.
*/
package nand_cfg_pkg;

   // Register byte addresses
   localparam logic [31:0] CONFIG_ADDR   = 32'h400e0000;
   localparam logic [31:0] CONTROL_ADDR  = 32'h400e0004;
   localparam logic [31:0] STATUS_ADDR   = 32'h400e0008;
   localparam logic [31:0] IRQ_EN_ADDR   = 32'h400e000c;
   localparam logic [31:0] IRQ_DIS_ADDR  = 32'h400e0010;
   localparam logic [31:0] IRQ_MASK_ADDR = 32'h400e0014;

   localparam int NUM_RDY = 1;

   // Configuration fields
   localparam int PAGE_LSB      = 0;
   localparam int WRITE_SPARE_EN_BIT    = 8;
   localparam int READ_SPARE_EN_BIT    = 9;
   localparam int EDGE_SEL_BIT  = 12;
   localparam int EDGE_MODE_BIT = 13;
   localparam int TOCYC_LSB     = 16;
   localparam int TOMUL_LSB     = 20;
   localparam logic [31:0] CONFIG_RESET = 32'h00000000;
   localparam logic [31:0] CONFIG_WMASK = 32'h007f3303;

   // Control fields
   localparam int CTRL_EN_BIT  = 0;
   localparam int CTRL_DIS_BIT = 1;
   localparam int CTRL_UPD_BIT = 4;

   // Status fields
   localparam int ST_ENABLED  = 0;
   localparam int ST_RISE     = 4;
   localparam int ST_FALL     = 5;
   localparam int ST_ACTIVE   = 8;
   localparam int ST_DIR      = 11;
   localparam int ST_CS_LSB   = 12;
   localparam int ST_XFER     = 16;
   localparam int ST_CMD      = 17;
   localparam int ST_TIMEOUT  = 20;
   localparam int ST_UNDEFINED_AREA_FLAG    = 21;
   localparam int ST_BUSYACC  = 22;
   localparam int ST_SIZEERR  = 23;
   localparam int ST_LINE_LSB = 24;
   localparam logic [31:0] EVT_MASK     = 32'h01f30030;
   localparam logic [31:0] STATUS_RESET = 32'h00000000;

   // Page layout base sizes, scaled by the page code
   localparam logic [12:0] MAIN_BASE  = 13'h0200;
   localparam logic [12:0] SPARE_BASE = 13'h0010;

   localparam logic [1:0] SIZE_WORD = 2'h2;

   typedef enum logic [0:0] {
      TO_IDLE = 1'b0,
      TO_WAIT = 1'b1
   } to_state_e;

   // Multiplier codes 0..7 scale by 1,16,128,256,1024,4096,65536,1048576
   function automatic logic [4:0] timeout_shift(input logic [2:0] code);
      case (code)
         3'h0:    timeout_shift = 5'h00;
         3'h1:    timeout_shift = 5'h04;
         3'h2:    timeout_shift = 5'h07;
         3'h3:    timeout_shift = 5'h08;
         3'h4:    timeout_shift = 5'h0a;
         3'h5:    timeout_shift = 5'h0c;
         3'h6:    timeout_shift = 5'h10;
         default: timeout_shift = 5'h14;
      endcase
   endfunction : timeout_shift

endpackage : nand_cfg_pkg

// File: design/rdy_edge_detect.sv
/*
 Ready/busy pin conditioning: three-stage synchroniser per line, a level
 that changes only when stages two and three agree, and edge pulses.
 Assumes asynchronous pins and a free-running mclk.
*/
`timescale 1ns/1ps
module rdy_edge_detect (
   input  wire logic                           mclk,
   input  wire logic                           reset,
   input  wire logic [nand_cfg_pkg::NUM_RDY-1:0] rdy_pin,
   output logic      [nand_cfg_pkg::NUM_RDY-1:0] rdy_level,
   output logic      [nand_cfg_pkg::NUM_RDY-1:0] rdy_rise,
   output logic      [nand_cfg_pkg::NUM_RDY-1:0] rdy_fall
);

   genvar i;
   generate
      for (i = 0; i < nand_cfg_pkg::NUM_RDY; i++) begin : g_line
         logic [2:0] sync;

         always_ff @(posedge mclk or posedge reset) begin
            if (reset) begin
               // Start at the pulled-up ready level so no false edge follows reset
               sync         <= 3'h7;
               rdy_level[i] <= 1'b1;
               rdy_rise[i]  <= 1'b0;
               rdy_fall[i]  <= 1'b0;
            end else begin
               sync <= {sync[1:0], rdy_pin[i]};
               // Only accept a new level once two stages agree
               if (sync[1] == sync[2]) begin
                  rdy_level[i] <= sync[2];
               end
               rdy_rise[i] <= (sync[1] == sync[2]) && sync[2] && !rdy_level[i];
               rdy_fall[i] <= (sync[1] == sync[2]) && !sync[2] && rdy_level[i];
            end
         end
      end
   endgenerate

endmodule : rdy_edge_detect

// File: design/nand_ctrl_config_status.sv
/*
 Configuration, control and status registers of the NAND controller:
 page layout, spare handling, ready/busy edge flags, data timeout, enable
 state, sticky event flags cleared by a status read, interrupt mask.
 Assumes a single-cycle register port and sequencer events on mclk.
*/
`timescale 1ns/1ps
// Overview of operation
// - Two-bit page code selects 512+16, 1024+32, 2048+64 or 4096+128 bytes
// - Write spare bit clear skips spare area on writes; set writes both
// - Read spare bit clear skips spare area on reads; set reads both
// - Edge select bit picks rising edges at zero, falling edges at one
// - Edge mode zero shows line levels; one shows only transitions
// - Timeout limit is cycle field times 1,16,128,256,1024,4096,65536,1048576
// - No ready rising edge before the limit sets the timeout error flag
// - Timeout flag at bit 20 holds until the status register is read
// - Control bit 0 written one enables, bit 1 written one disables
// - Status bit 0 shows enable state, untouched by status reads
// - Status bit 4 sets on selected line rising edge, clears on read
// - Status bit 5 sets on selected line falling edge, clears on read
// - Status bit 8 shows the controller active on the memory
// - Status bit 11 shows command direction, also set through control
// - Status field holds targeted chip select, also set through control
// - Status bit 16 sets on transfer done, clears on read
// - Status bit 17 sets on command done, clears on read
// - Status bit 21 sets on undefined area access, clears on read
// - Status bit 22 sets on access while busy, clears on read
// - Non-word access to the memory area sets status bit 23
// - Per-line bits from 24 set on configured edge, clear on read
// - Event flags have enable, disable and mask bits at same positions
module nand_ctrl_config_status (
   input  wire logic                           mclk,
   input  wire logic                           reset,
   input  wire logic [31:0]                    reg_addr,
   input  wire logic [31:0]                    reg_wdata,
   input  wire logic                           reg_wr,
   input  wire logic                           reg_rd,
   output logic      [31:0]                    reg_rdata,
   input  wire logic [nand_cfg_pkg::NUM_RDY-1:0] rdy_pin,
   input  wire logic                           cmd_issue,
   input  wire logic                           cmd_is_write,
   input  wire logic [2:0]                     cmd_cs,
   input  wire logic                           ctrl_busy,
   input  wire logic                           xfer_done,
   input  wire logic                           cmd_done,
   input  wire logic                           undefined_area_flag_access,
   input  wire logic                           mem_access,
   input  wire logic [1:0]                     mem_access_size,
   input  wire logic                           rdy_wait_start,
   output logic                                ctrl_enabled,
   output logic      [1:0]                     page_layout_sel,
   output logic      [12:0]                    wr_xfer_bytes,
   output logic      [12:0]                    rd_xfer_bytes,
   output logic                                irq
);

   logic [31:0]                  config_reg;
   logic [31:0]                  flags;
   logic [31:0]                  imask;
   logic [31:0]                  evt_set;
   logic [31:0]                  status_word;
   logic                         op_direction;
   logic [2:0]                   target_cs_id;
   logic                         ctrl_active_flag;
   logic [nand_cfg_pkg::NUM_RDY-1:0] rdy_level;
   logic [nand_cfg_pkg::NUM_RDY-1:0] rdy_rise;
   logic [nand_cfg_pkg::NUM_RDY-1:0] rdy_fall;
   logic [nand_cfg_pkg::NUM_RDY-1:0] line_edge;
   logic                         sel_rise;
   logic                         sel_fall;
   logic                         wr_config;
   logic                         wr_control;
   logic                         rd_status;
   logic                         unmapped;
   logic [12:0]                  main_bytes;
   logic [12:0]                  spare_bytes;
   logic [23:0]                  to_limit;
   logic [23:0]                  to_count;
   logic                         to_expire;
   nand_cfg_pkg::to_state_e      to_state;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);

   rdy_edge_detect u_rdy (
      .mclk      (mclk),
      .reset     (reset),
      .rdy_pin   (rdy_pin),
      .rdy_level (rdy_level),
      .rdy_rise  (rdy_rise),
      .rdy_fall  (rdy_fall)
   );

   // Address decode
   assign wr_config  = reg_wr && (reg_addr == nand_cfg_pkg::CONFIG_ADDR);
   assign wr_control = reg_wr && (reg_addr == nand_cfg_pkg::CONTROL_ADDR);
   assign rd_status  = reg_rd && (reg_addr == nand_cfg_pkg::STATUS_ADDR);
   assign unmapped   = (reg_wr || reg_rd) &&
                       (reg_addr != nand_cfg_pkg::CONFIG_ADDR) &&
                       (reg_addr != nand_cfg_pkg::CONTROL_ADDR) &&
                       (reg_addr != nand_cfg_pkg::STATUS_ADDR) &&
                       (reg_addr != nand_cfg_pkg::IRQ_EN_ADDR) &&
                       (reg_addr != nand_cfg_pkg::IRQ_DIS_ADDR) &&
                       (reg_addr != nand_cfg_pkg::IRQ_MASK_ADDR);

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         config_reg <= nand_cfg_pkg::CONFIG_RESET;
      end else if (wr_config) begin
         config_reg <= reg_wdata & nand_cfg_pkg::CONFIG_WMASK;
      end
   end

   // Page layout and transfer sizes
   assign main_bytes  = nand_cfg_pkg::MAIN_BASE << config_reg[nand_cfg_pkg::PAGE_LSB +: 2];
   assign spare_bytes = nand_cfg_pkg::SPARE_BASE << config_reg[nand_cfg_pkg::PAGE_LSB +: 2];

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         page_layout_sel <= 2'h0;
         wr_xfer_bytes   <= 13'h0000;
         rd_xfer_bytes   <= 13'h0000;
      end else begin
         page_layout_sel <= config_reg[nand_cfg_pkg::PAGE_LSB +: 2];
         wr_xfer_bytes   <= config_reg[nand_cfg_pkg::WRITE_SPARE_EN_BIT] ?
                            main_bytes + spare_bytes : main_bytes;
         rd_xfer_bytes   <= config_reg[nand_cfg_pkg::READ_SPARE_EN_BIT] ?
                            main_bytes + spare_bytes : main_bytes;
      end
   end

   // Enable state; disable wins if both command bits are written
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         ctrl_enabled <= 1'b0;
      end else if (wr_control) begin
         if (reg_wdata[nand_cfg_pkg::CTRL_DIS_BIT]) begin
            ctrl_enabled <= 1'b0;
         end else if (reg_wdata[nand_cfg_pkg::CTRL_EN_BIT]) begin
            ctrl_enabled <= 1'b1;
         end
      end
   end

   // Command direction and chip select, from the sequencer or software
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         op_direction <= 1'b0;
         target_cs_id <= 3'h0;
      end else if (wr_control && reg_wdata[nand_cfg_pkg::CTRL_UPD_BIT]) begin
         op_direction <= reg_wdata[nand_cfg_pkg::ST_DIR];
         target_cs_id <= reg_wdata[nand_cfg_pkg::ST_CS_LSB +: 3];
      end else if (cmd_issue) begin
         op_direction <= cmd_is_write;
         target_cs_id <= cmd_cs;
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         ctrl_active_flag <= 1'b0;
      end else begin
         ctrl_active_flag <= ctrl_busy;
      end
   end

   // With a single ready/busy line every chip select decodes to line 0
   assign sel_rise = rdy_rise[0];
   assign sel_fall = rdy_fall[0];

   genvar i;
   generate
      for (i = 0; i < nand_cfg_pkg::NUM_RDY; i++) begin : g_line
         assign line_edge[i] = config_reg[nand_cfg_pkg::EDGE_SEL_BIT] ?
                               rdy_fall[i] : rdy_rise[i];
      end
   endgenerate

   // Data timeout
   assign to_limit = 24'(config_reg[nand_cfg_pkg::TOCYC_LSB +: 4]) <<
                     nand_cfg_pkg::timeout_shift(config_reg[nand_cfg_pkg::TOMUL_LSB +: 3]);
   assign to_expire = (to_state == nand_cfg_pkg::TO_WAIT) && ctrl_enabled &&
                      !sel_rise && (to_count == to_limit);

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         to_state <= nand_cfg_pkg::TO_IDLE;
         to_count <= 24'h000000;
      end else begin
         case (to_state)
            nand_cfg_pkg::TO_IDLE: begin
               to_count <= 24'h000000;
               if (rdy_wait_start && ctrl_enabled) begin
                  to_state <= nand_cfg_pkg::TO_WAIT;
               end
            end
            nand_cfg_pkg::TO_WAIT: begin
               to_count <= to_count + 24'h000001;
               if (sel_rise || to_expire || !ctrl_enabled) begin
                  to_state <= nand_cfg_pkg::TO_IDLE;
               end
            end
            default: begin
               to_state <= nand_cfg_pkg::TO_IDLE;
            end
         endcase
      end
   end

   // Event sources for the sticky flags
   always_comb begin
      evt_set = 32'h00000000;
      evt_set[nand_cfg_pkg::ST_RISE]    = sel_rise;
      evt_set[nand_cfg_pkg::ST_FALL]    = sel_fall;
      evt_set[nand_cfg_pkg::ST_XFER]    = xfer_done;
      evt_set[nand_cfg_pkg::ST_CMD]     = cmd_done;
      evt_set[nand_cfg_pkg::ST_TIMEOUT] = to_expire;
      evt_set[nand_cfg_pkg::ST_UNDEFINED_AREA_FLAG]   = undefined_area_flag_access || unmapped;
      evt_set[nand_cfg_pkg::ST_BUSYACC] = mem_access && ctrl_busy;
      evt_set[nand_cfg_pkg::ST_SIZEERR] = mem_access &&
                                 (mem_access_size != nand_cfg_pkg::SIZE_WORD);
      evt_set[nand_cfg_pkg::ST_LINE_LSB +: nand_cfg_pkg::NUM_RDY] = line_edge;
   end

   // A set in the reading cycle survives the clear
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         flags <= nand_cfg_pkg::STATUS_RESET;
      end else begin
         flags <= ((flags & ~{32{rd_status}}) | evt_set) & nand_cfg_pkg::EVT_MASK;
      end
   end

   always_comb begin
      status_word = flags;
      status_word[nand_cfg_pkg::ST_ENABLED]    = ctrl_enabled;
      status_word[nand_cfg_pkg::ST_ACTIVE]     = ctrl_active_flag;
      status_word[nand_cfg_pkg::ST_DIR]        = op_direction;
      status_word[nand_cfg_pkg::ST_CS_LSB +: 3] = target_cs_id;
      if (!config_reg[nand_cfg_pkg::EDGE_MODE_BIT]) begin
         status_word[nand_cfg_pkg::ST_LINE_LSB +: nand_cfg_pkg::NUM_RDY] = rdy_level;
      end
   end

   // Interrupt enable, disable and mask
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         imask <= 32'h00000000;
      end else if (reg_wr && (reg_addr == nand_cfg_pkg::IRQ_EN_ADDR)) begin
         imask <= imask | (reg_wdata & nand_cfg_pkg::EVT_MASK);
      end else if (reg_wr && (reg_addr == nand_cfg_pkg::IRQ_DIS_ADDR)) begin
         imask <= imask & ~reg_wdata;
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         irq <= 1'b0;
      end else begin
         irq <= |(status_word & imask);
      end
   end

   // Read data, valid in the cycle after the strobe
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         reg_rdata <= 32'h00000000;
      end else if (reg_rd) begin
         case (reg_addr)
            nand_cfg_pkg::CONFIG_ADDR:   reg_rdata <= config_reg;
            nand_cfg_pkg::STATUS_ADDR:   reg_rdata <= status_word;
            nand_cfg_pkg::IRQ_MASK_ADDR: reg_rdata <= imask;
            default:                     reg_rdata <= 32'h00000000;
         endcase
      end
   end

   sequence s_enable_write;
      wr_control && reg_wdata[nand_cfg_pkg::CTRL_EN_BIT] &&
         !reg_wdata[nand_cfg_pkg::CTRL_DIS_BIT];
   endsequence

   sequence s_cfg_steady;
      $stable(config_reg) [*2];
   endsequence

   a_enable_cmd:
      assert property (s_enable_write |=> ctrl_enabled ##1 (ctrl_enabled || reg_wr))
      else $error("enable command did not enable");
   a_disable_cmd:
      assert property (wr_control && reg_wdata[nand_cfg_pkg::CTRL_DIS_BIT] |=> !ctrl_enabled)
      else $error("disable command did not disable");
   a_enable_read:
      assert property (rd_status |=> $stable(ctrl_enabled) && reg_rdata[0] == ctrl_enabled)
      else $error("status read disturbed enable state");
   a_timeout_set:
      assert property (to_expire |=> flags[nand_cfg_pkg::ST_TIMEOUT] &&
                       to_state == nand_cfg_pkg::TO_IDLE)
      else $error("timeout expiry did not raise the flag");
   a_timeout_clear:
      assert property (rd_status && !to_expire |=> !flags[nand_cfg_pkg::ST_TIMEOUT])
      else $error("timeout flag survived a status read");
   a_rise_flag:
      assert property (sel_rise |=> flags[nand_cfg_pkg::ST_RISE])
      else $error("rising edge flag not set");
   a_fall_flag:
      assert property (sel_fall |=> flags[nand_cfg_pkg::ST_FALL])
      else $error("falling edge flag not set");
   a_size_error:
      assert property (mem_access && mem_access_size != nand_cfg_pkg::SIZE_WORD
                       |=> flags[nand_cfg_pkg::ST_SIZEERR])
      else $error("access size error not flagged");
   a_level_mode:
      assert property (!config_reg[nand_cfg_pkg::EDGE_MODE_BIT]
                       |-> status_word[nand_cfg_pkg::ST_LINE_LSB] == rdy_level[0])
      else $error("line field does not follow level");
   a_active_flag:
      assert property (ctrl_busy |=> status_word[nand_cfg_pkg::ST_ACTIVE])
      else $error("active flag missing");
   a_wr_spare:
      assert property (s_cfg_steady |-> wr_xfer_bytes ==
                       (config_reg[nand_cfg_pkg::WRITE_SPARE_EN_BIT] ? main_bytes + spare_bytes
                                                             : main_bytes))
      else $error("write transfer size wrong");
   a_rd_spare:
      assert property (s_cfg_steady |-> rd_xfer_bytes ==
                       (config_reg[nand_cfg_pkg::READ_SPARE_EN_BIT] ? main_bytes + spare_bytes
                                                             : main_bytes))
      else $error("read transfer size wrong");
   a_irq_follow:
      assert property (|(status_word & imask) |=> irq)
      else $error("interrupt not raised");
   a_status_read:
      assert property (rd_status |=> reg_rdata == $past(status_word))
      else $error("status read data wrong");
   a_line_flag:
      assert property (line_edge[0] |=> flags[nand_cfg_pkg::ST_LINE_LSB])
      else $error("line edge flag not set");
   a_xfer_flag:
      assert property (xfer_done |=> flags[nand_cfg_pkg::ST_XFER])
      else $error("transfer done flag not set");

endmodule : nand_ctrl_config_status

// File: dv/nand_rdy_model.sv
/*
 Ready/busy line of a NAND device: goes busy (low) for a fixed time
 whenever the bench asks for it, otherwise pulled up to ready.
 Assumes busy_go is a one-cycle pulse on mclk.
*/
`timescale 1ns/1ps
module nand_rdy_model #(
   parameter int BUSY_CYCLES = 40
) (
   input  wire logic mclk,
   input  wire logic busy_go,
   output logic      rdy_pin
);
   int cnt = 0;
   always @(posedge mclk) begin
      if (busy_go)
         cnt <= BUSY_CYCLES;
      else if (cnt != 0)
         cnt <= cnt - 1;
   end
   // Pull-up holds the line at ready while the array is idle
   assign rdy_pin = (cnt == 0);
endmodule : nand_rdy_model

// File: dv/testbench.sv
/*
 Self-checking bench for the NAND configuration and status block.
 Assumes the register map and field positions of nand_cfg_pkg.
*/
`timescale 1ns/1ps
module testbench;
   logic        mclk = 1'b0;
   logic        reset = 1'b1;
   logic [31:0] reg_addr = '0;
   logic [31:0] reg_wdata = '0;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic        rd_d = 1'b0;
   logic [31:0] reg_rdata;
   logic        rdy_pin;
   logic        busy_go = 1'b0;
   logic        cmd_issue = 1'b0;
   logic        cmd_is_write = 1'b0;
   logic [2:0]  cmd_cs = '0;
   logic        ctrl_busy = 1'b0;
   logic [4:0]  ev = '0;
   logic [1:0]  mem_access_size = 2'h2;
   logic        ctrl_enabled;
   logic        irq;
   logic [1:0]  page_layout_sel;
   logic [12:0] wr_xfer_bytes;
   logic [12:0] rd_xfer_bytes;
   logic [31:0] exp_q[$];
   logic [31:0] msk_q[$];
   int          error_cnt = 0;
   int          n_checks = 0;
   int          ev_bit[5] = '{16, 17, 21, 22, 23};

   nand_ctrl_config_status dut (.mclk(mclk), .reset(reset), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .rdy_pin(rdy_pin), .cmd_issue(cmd_issue), .cmd_is_write(cmd_is_write),
      .cmd_cs(cmd_cs), .ctrl_busy(ctrl_busy), .xfer_done(ev[0]), .cmd_done(ev[1]),
      .undefined_area_flag_access(ev[2]), .mem_access(ev[3]), .mem_access_size(mem_access_size),
      .rdy_wait_start(ev[4]), .ctrl_enabled(ctrl_enabled),
      .page_layout_sel(page_layout_sel), .wr_xfer_bytes(wr_xfer_bytes),
      .rd_xfer_bytes(rd_xfer_bytes), .irq(irq));
   nand_rdy_model #(.BUSY_CYCLES(40)) partner (.mclk(mclk), .busy_go(busy_go),
      .rdy_pin(rdy_pin));

   initial forever #50 mclk = ~mclk;

   task end_of_test;
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : end_of_test

   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task wr(input logic [31:0] a, input logic [31:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask : wr

   task rd(input logic [31:0] a, input logic [31:0] e, input logic [31:0] m);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      exp_q.push_back(e);
      msk_q.push_back(m);
      @(posedge mclk);
      reg_rd <= 1'b0;
   endtask : rd

   task pulse(input logic [4:0] v);
      @(posedge mclk);
      ev <= v;
      @(posedge mclk);
      ev <= '0;
   endtask : pulse

   task busy;
      @(posedge mclk);
      busy_go <= 1'b1;
      @(posedge mclk);
      busy_go <= 1'b0;
   endtask : busy

   task idle(input int n);
      repeat (n) @(posedge mclk);
   endtask : idle

   task tdone(input string nm);
      $display("test %s finished", nm);
   endtask : tdone

   always @(posedge mclk) rd_d <= reg_rd;

   // Read data is defined only in the cycle after the strobe
   always @(negedge mclk) begin
      logic [31:0] e;
      logic [31:0] m;
      if (rd_d) begin
         e = exp_q.pop_front();
         m = msk_q.pop_front();
         chk("reg_rdata", e & m, reg_rdata & m);
      end
   end

   initial begin
      repeat (20000) @(posedge mclk);
      error_cnt++;
      $display("CHECK FAILED run length expected finish seen timeout");
      end_of_test();
   end

   initial begin
      logic [31:0] cfg;
      logic [31:0] mn;
      logic [31:0] sp;
      void'($urandom(32'hf3ba96a1));
      idle(5);
      reset <= 1'b0;
      rd(nand_cfg_pkg::CONFIG_ADDR, nand_cfg_pkg::CONFIG_RESET, '1);
      rd(nand_cfg_pkg::STATUS_ADDR, nand_cfg_pkg::STATUS_RESET, 32'hfeffffff);
      rd(nand_cfg_pkg::CONTROL_ADDR, 32'h0, '1);
      rd(nand_cfg_pkg::IRQ_MASK_ADDR, 32'h0, '1);
      rd(32'h400e0040, 32'h0, '1);
      rd(nand_cfg_pkg::STATUS_ADDR, 32'h00200000, 32'h00200000);
      tdone("reset");
      for (int i = 0; i < 8; i++) begin
         cfg = $urandom & nand_cfg_pkg::CONFIG_WMASK & 32'hfffffcfc;
         cfg = cfg | 32'(i % 4) | (32'(i / 4) << 8) | (32'((i ^ (i / 4)) & 1) << 9);
         mn = 32'h200 << (i % 4);
         sp = 32'h10 << (i % 4);
         wr(nand_cfg_pkg::CONFIG_ADDR, cfg);
         idle(3);
         @(negedge mclk);
         chk("page_layout_sel", 32'(i % 4), {30'h0, page_layout_sel});
         chk("wr_xfer_bytes", mn + (cfg[8] ? sp : 0), {19'h0, wr_xfer_bytes});
         chk("rd_xfer_bytes", mn + (cfg[9] ? sp : 0), {19'h0, rd_xfer_bytes});
         rd(nand_cfg_pkg::CONFIG_ADDR, cfg, '1);
      end
      tdone("layout");
      wr(nand_cfg_pkg::CONTROL_ADDR, 32'h1);
      rd(nand_cfg_pkg::STATUS_ADDR, 32'h1, 32'h1);
      rd(nand_cfg_pkg::STATUS_ADDR, 32'h1, 32'h1);
      @(negedge mclk);
      chk("ctrl_enabled", 32'h1, {31'h0, ctrl_enabled});
      wr(nand_cfg_pkg::CONTROL_ADDR, 32'h2);
      rd(nand_cfg_pkg::STATUS_ADDR, 32'h0, 32'h1);
      wr(nand_cfg_pkg::CONTROL_ADDR, 32'h1);
      wr(nand_cfg_pkg::CONTROL_ADDR, 32'h3);
      rd(nand_cfg_pkg::STATUS_ADDR, 32'h0, 32'h1);
      tdone("enable");
      for (int k = 0; k < 5; k++) begin
         mem_access_size <= (k == 4) ? 2'h1 : nand_cfg_pkg::SIZE_WORD;
         ctrl_busy <= (k == 3);
         pulse((k < 3) ? 5'(1 << k) : 5'h08);
         rd(nand_cfg_pkg::STATUS_ADDR, 32'h1 << ev_bit[k],
            32'h00c00000 | (32'h1 << ev_bit[k]));
         rd(nand_cfg_pkg::STATUS_ADDR, 32'h0,
            32'h00c00000 | (32'h1 << ev_bit[k]));
      end
      tdone("events");
      ctrl_busy <= 1'b1;
      cmd_is_write <= 1'b1;
      cmd_cs <= 3'h5;
      cmd_issue <= 1'b1;
      @(posedge mclk);
      cmd_issue <= 1'b0;
      rd(nand_cfg_pkg::STATUS_ADDR, 32'h5900, 32'h7900);
      rd(nand_cfg_pkg::STATUS_ADDR, 32'h5900, 32'h7900);
      ctrl_busy <= 1'b0;
      wr(nand_cfg_pkg::CONTROL_ADDR, 32'h3010);
      rd(nand_cfg_pkg::STATUS_ADDR, 32'h3000, 32'h7900);
      tdone("command");
      for (int s = 0; s < 2; s++) begin
         wr(nand_cfg_pkg::CONFIG_ADDR, 32'h2000 | (32'(s) << 12));
         rd(nand_cfg_pkg::STATUS_ADDR, 32'h0, 32'h01000030);
         busy();
         idle(10);
         rd(nand_cfg_pkg::STATUS_ADDR, 32'h20 | (32'(s) << 24), 32'h01000030);
         idle(45);
         rd(nand_cfg_pkg::STATUS_ADDR, 32'h10 | (32'(1 - s) << 24), 32'h01000030);
      end
      wr(nand_cfg_pkg::CONFIG_ADDR, 32'h0);
      rd(nand_cfg_pkg::STATUS_ADDR, 32'h01000000, 32'h01000000);
      busy();
      idle(10);
      rd(nand_cfg_pkg::STATUS_ADDR, 32'h0, 32'h01000000);
      idle(45);
      tdone("ready line");
      wr(nand_cfg_pkg::CONTROL_ADDR, 32'h1);
      wr(nand_cfg_pkg::CONFIG_ADDR, 32'h00130000);
      rd(nand_cfg_pkg::STATUS_ADDR, 32'h01000010, 32'h01000030);
      pulse(5'h10);
      idle(40);
      rd(nand_cfg_pkg::STATUS_ADDR, 32'h0, 32'h00100000);
      idle(20);
      rd(nand_cfg_pkg::STATUS_ADDR, 32'h00100000, 32'h00100000);
      rd(nand_cfg_pkg::STATUS_ADDR, 32'h0, 32'h00100000);
      wr(nand_cfg_pkg::CONFIG_ADDR, 32'h00050000);
      pulse(5'h10);
      idle(2);
      rd(nand_cfg_pkg::STATUS_ADDR, 32'h0, 32'h00100000);
      idle(3);
      rd(nand_cfg_pkg::STATUS_ADDR, 32'h00100000, 32'h00100000);
      tdone("timeout");
      wr(nand_cfg_pkg::IRQ_EN_ADDR, '1);
      rd(nand_cfg_pkg::IRQ_MASK_ADDR, nand_cfg_pkg::EVT_MASK, '1);
      wr(nand_cfg_pkg::IRQ_DIS_ADDR, 32'hfffeffff);
      rd(nand_cfg_pkg::IRQ_MASK_ADDR, 32'h00010000, '1);
      idle(2);
      @(negedge mclk);
      chk("irq", 32'h0, {31'h0, irq});
      pulse(5'h01);
      idle(3);
      @(negedge mclk);
      chk("irq", 32'h1, {31'h0, irq});
      rd(nand_cfg_pkg::STATUS_ADDR, 32'h00010000, 32'h00010000);
      idle(2);
      @(negedge mclk);
      chk("irq", 32'h0, {31'h0, irq});
      tdone("interrupt");
      end_of_test();
   end
endmodule : testbench
